// file: verilog/sbie_irq_enable.v
// APB-reached interrupt-enable and acknowledge-judgement register of a
// serial bus interface, with its request gating.
// Word 0x00 holds enables and ack bits; word 0x04 is a read-only flag view.
// Writes take effect on the APB access edge; reads are captured at setup.
// Assumes all flag and acknowledge inputs come from logic on pclk.
// Assumes the status logic clears its own flags; this block only gates them.
//
// What this block does
// - Transmit-empty request only while buffer-empty flag and bit 7 enable are 1.
// - Transmit-end request raised, with bit 6 set, when transmit-end flag sets.
// - Transmit-end request drops when its flag or its enable clears.
// - Bit 5 gates receive-full and, in synchronous format, overrun error.
// - Receive-full request drops when its flag or its enable clears.
// - Bit 4 gates NACK request from no-ack/arbitration flags, and sync overrun.
// - NACK request drops when its enable clears or both no-ack and arbitration-lost flags clear.
// - Stop-seen request passes only while bit 3 enable is 1.
// - Ack check 0 ignores received ack; 1 halts transfer on ack of 1.
`timescale 1ns/1ps
`include "sbie_map.vh"

module sbie_irq_enable (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  tx_buf_empty_flag,
  tx_done_flag,
  rx_buf_full_flag,
  no_ack_flag,
  arbitration_lost_flag,
  rx_lost_word_flag,
  stop_seen_flag,
  sync_format,
  rx_ack_bit,
  ack_sampled,
  xfer_start,
  tx_empty_irq,
  tx_done_irq,
  rx_full_irq,
  error_irq,
  nack_irq,
  stop_seen_irq,
  tx_ack_bit,
  ack_check_en,
  halt_xfer
);
  input  wire                      pclk;
  input  wire                      presetn;
  input  wire                      psel;
  input  wire                      penable;
  input  wire                      pwrite;
  input  wire [`SBIE_ADDR_W-1:0]   paddr;
  input  wire [`SBIE_DATA_W-1:0]   pwdata;
  output wire [`SBIE_DATA_W-1:0]   prdata;
  output wire                      pready;
  output wire                      pslverr;
  input  wire                      tx_buf_empty_flag;
  input  wire                      tx_done_flag;
  input  wire                      rx_buf_full_flag;
  input  wire                      no_ack_flag;
  input  wire                      arbitration_lost_flag;
  input  wire                      rx_lost_word_flag;
  input  wire                      stop_seen_flag;
  input  wire                      sync_format;
  input  wire                      rx_ack_bit;
  input  wire                      ack_sampled;
  input  wire                      xfer_start;
  output wire                      tx_empty_irq;
  output wire                      tx_done_irq;
  output wire                      rx_full_irq;
  output wire                      error_irq;
  output wire                      nack_irq;
  output wire                      stop_seen_irq;
  output wire                      tx_ack_bit;
  output wire                      ack_check_en;
  output wire                      halt_xfer;

  // ========================================================
  // Address decode helpers
  function is_irq_en;
    input [`SBIE_ADDR_W-1:0] a;
    begin
      is_irq_en = (a == `SBIE_OFS_IRQ_EN);
    end
  endfunction

  function is_flags;
    input [`SBIE_ADDR_W-1:0] a;
    begin
      is_flags = (a == `SBIE_OFS_FLAGS);
    end
  endfunction

  // ========================================================
  // Declarations
  reg  [`SBIE_REG_W-1:0]   irq_en_ff;
  reg  [`SBIE_REG_W-1:0]   nxt_irq_en;
  reg                      ack_rx_ff;
  reg                      nxt_ack_rx;
  reg                      halt_ff;
  reg                      nxt_halt;
  reg  [`SBIE_DATA_W-1:0]  prdata_ff;
  reg  [`SBIE_DATA_W-1:0]  nxt_prdata;
  reg                      pslverr_ff;
  reg                      nxt_pslverr;
  reg  [`SBIE_REG_W-1:0]   irq_en_view;
  reg  [`SBIE_FLAGS_W-1:0] flags_view;
  wire [`SBIE_NUM_IRQ-1:0] irq_vec;
  wire                     setup;
  wire                     wr_en_reg;
  wire                     bad_access;
  wire                     access;
  wire [`SBIE_REG_W-1:0]   wr_byte;
  wire                     ack_is_nack;
  wire                     halt_set;
  wire                     halt_clr;

  // ========================================================
  // APB slave: zero wait states; a write lands on the access edge only
  assign setup      = psel & ~penable;
  assign access     = psel & penable & pready;
  assign wr_en_reg  = access & pwrite & is_irq_en(paddr);
  assign bad_access = setup & ~is_irq_en(paddr) & (pwrite | ~is_flags(paddr));
  assign pready     = 1'b1;
  assign wr_byte    = pwdata[`SBIE_REG_W-1:0] & `SBIE_IRQ_EN_WMASK;

  // ========================================================
  // Enable register; received-ack bit is not writable
  always @* begin
    nxt_irq_en = irq_en_ff;
    if (wr_en_reg) begin
      nxt_irq_en = wr_byte;
    end
  end

  // ========================================================
  // Received acknowledge capture and continuous-transfer halt
  assign ack_is_nack = ack_sampled & rx_ack_bit;
  assign halt_set    = ack_is_nack & irq_en_ff[`SBIE_BIT_ACK_CHK];
  assign halt_clr    = xfer_start;

  always @* begin
    nxt_ack_rx = ack_rx_ff;
    if (ack_sampled) begin
      nxt_ack_rx = rx_ack_bit;
    end
  end

  always @* begin
    nxt_halt = halt_ff;
    if (halt_clr) begin
      nxt_halt = 1'b0;
    end
    // Set wins over a same-cycle restart
    if (halt_set) begin
      nxt_halt = 1'b1;
    end
  end

  // ========================================================
  // Read views
  always @* begin
    irq_en_view = irq_en_ff;
    irq_en_view[`SBIE_BIT_ACK_RX] = ack_rx_ff;
  end

  always @* begin
    flags_view = {`SBIE_FLAGS_W{1'b0}};
    flags_view[`SBIE_FV_TX_EMPTY] = tx_buf_empty_flag;
    flags_view[`SBIE_FV_TX_DONE]  = tx_done_flag;
    flags_view[`SBIE_FV_RX_FULL]  = rx_buf_full_flag;
    flags_view[`SBIE_FV_NO_ACK]   = no_ack_flag;
    flags_view[`SBIE_FV_ARB_LOST] = arbitration_lost_flag;
    flags_view[`SBIE_FV_RX_LOST]  = rx_lost_word_flag;
    flags_view[`SBIE_FV_STOP]     = stop_seen_flag;
    flags_view[`SBIE_FV_SYNC]     = sync_format;
    flags_view[`SBIE_FV_IRQ_HI:`SBIE_FV_IRQ_LO] = irq_vec;
    flags_view[`SBIE_FV_HALT]     = halt_ff;
  end

  // Read data latched in setup, held through the access phase
  always @* begin
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = `SBIE_ZERO32;
      if (!pwrite) begin
        case (paddr)
          `SBIE_OFS_IRQ_EN: begin
            nxt_prdata[`SBIE_REG_W-1:0] = irq_en_view;
          end
          `SBIE_OFS_FLAGS: begin
            nxt_prdata[`SBIE_FLAGS_W-1:0] = flags_view;
          end
          default: begin
            nxt_prdata = `SBIE_ZERO32;
          end
        endcase
      end
    end
  end

  // Error latched in setup: unmapped address or write to the flag view
  always @* begin
    nxt_pslverr = pslverr_ff;
    if (setup) begin
      nxt_pslverr = bad_access;
    end
  end

  // ========================================================
  // Registers
  // Enables and ack bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= `SBIE_IRQ_EN_RST;
    end else begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  // Last received acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_rx_ff <= 1'b0;
    end else begin
      ack_rx_ff <= nxt_ack_rx;
    end
  end

  // Continuous-transfer halt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ff <= 1'b0;
    end else begin
      halt_ff <= nxt_halt;
    end
  end

  // Read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= `SBIE_ZERO32;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Bus error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ========================================================
  // Request gating
  sbie_irq_gate u_gate (
    .pclk                  (pclk),
    .presetn               (presetn),
    .en_tx_empty           (irq_en_ff[`SBIE_BIT_TX_EMPTY]),
    .en_tx_end             (irq_en_ff[`SBIE_BIT_TX_END]),
    .en_rx_full            (irq_en_ff[`SBIE_BIT_RX_FULL]),
    .en_nack               (irq_en_ff[`SBIE_BIT_NACK]),
    .en_stop               (irq_en_ff[`SBIE_BIT_STOP]),
    .sync_format           (sync_format),
    .tx_buf_empty_flag     (tx_buf_empty_flag),
    .tx_done_flag          (tx_done_flag),
    .rx_buf_full_flag      (rx_buf_full_flag),
    .no_ack_flag           (no_ack_flag),
    .arbitration_lost_flag (arbitration_lost_flag),
    .rx_lost_word_flag     (rx_lost_word_flag),
    .stop_seen_flag        (stop_seen_flag),
    .irq_vec               (irq_vec)
  );

  // ========================================================
  // Outputs
  assign tx_empty_irq  = irq_vec[`SBIE_IRQ_TX_EMPTY];
  assign tx_done_irq   = irq_vec[`SBIE_IRQ_TX_DONE];
  assign rx_full_irq   = irq_vec[`SBIE_IRQ_RX_FULL];
  assign error_irq     = irq_vec[`SBIE_IRQ_ERROR];
  assign nack_irq      = irq_vec[`SBIE_IRQ_NACK];
  assign stop_seen_irq = irq_vec[`SBIE_IRQ_STOP];

  // ========================================================
  // Acknowledge control outputs
  assign tx_ack_bit    = irq_en_ff[`SBIE_BIT_ACK_TX];
  assign ack_check_en  = irq_en_ff[`SBIE_BIT_ACK_CHK];
  assign halt_xfer     = halt_ff;

  // ========================================================
  // Bus outputs
  assign prdata        = prdata_ff;
  assign pslverr       = pslverr_ff;

endmodule

// file: include/sbie_map.vh
// Register map, field positions and reset values of the serial bus
// interrupt-enable block. Definitions only; included by bare name.
`ifndef SBIE_MAP_VH
`define SBIE_MAP_VH

// ========================================================
// APB geometry
`define SBIE_ADDR_W        8
`define SBIE_DATA_W        32
`define SBIE_ZERO32        32'h0000_0000

// ========================================================
// Register byte addresses
`define SBIE_OFS_IRQ_EN    8'h00
`define SBIE_OFS_FLAGS     8'h04

// ========================================================
// serial_bus_irq_enable fields
`define SBIE_REG_W         8
`define SBIE_IRQ_EN_RST    8'h00
`define SBIE_IRQ_EN_WMASK  8'hfd
`define SBIE_BIT_TX_EMPTY  7
`define SBIE_BIT_TX_END    6
`define SBIE_BIT_RX_FULL   5
`define SBIE_BIT_NACK      4
`define SBIE_BIT_STOP      3
`define SBIE_BIT_ACK_CHK   2
`define SBIE_BIT_ACK_RX    1
`define SBIE_BIT_ACK_TX    0

// ========================================================
// Flag view fields (read only)
`define SBIE_FLAGS_W       16
`define SBIE_FV_TX_EMPTY   0
`define SBIE_FV_TX_DONE    1
`define SBIE_FV_RX_FULL    2
`define SBIE_FV_NO_ACK     3
`define SBIE_FV_ARB_LOST   4
`define SBIE_FV_RX_LOST    5
`define SBIE_FV_STOP       6
`define SBIE_FV_SYNC       7
`define SBIE_FV_IRQ_LO     8
`define SBIE_FV_IRQ_HI     13
`define SBIE_FV_HALT       14

// ========================================================
// Request vector positions
`define SBIE_NUM_IRQ       6
`define SBIE_IRQ_TX_EMPTY  0
`define SBIE_IRQ_TX_DONE   1
`define SBIE_IRQ_RX_FULL   2
`define SBIE_IRQ_ERROR     3
`define SBIE_IRQ_NACK      4
`define SBIE_IRQ_STOP      5

`endif

// file: verilog/sbie_irq_gate.v
// Gates the seven status flags with their enable bits into six registered
// interrupt requests. Assumes flags come from logic on pclk.
`timescale 1ns/1ps
`include "sbie_map.vh"

module sbie_irq_gate (
  pclk,
  presetn,
  en_tx_empty,
  en_tx_end,
  en_rx_full,
  en_nack,
  en_stop,
  sync_format,
  tx_buf_empty_flag,
  tx_done_flag,
  rx_buf_full_flag,
  no_ack_flag,
  arbitration_lost_flag,
  rx_lost_word_flag,
  stop_seen_flag,
  irq_vec
);
  input  wire                      pclk;
  input  wire                      presetn;
  input  wire                      en_tx_empty;
  input  wire                      en_tx_end;
  input  wire                      en_rx_full;
  input  wire                      en_nack;
  input  wire                      en_stop;
  input  wire                      sync_format;
  input  wire                      tx_buf_empty_flag;
  input  wire                      tx_done_flag;
  input  wire                      rx_buf_full_flag;
  input  wire                      no_ack_flag;
  input  wire                      arbitration_lost_flag;
  input  wire                      rx_lost_word_flag;
  input  wire                      stop_seen_flag;
  output wire [`SBIE_NUM_IRQ-1:0]  irq_vec;

  reg  [`SBIE_NUM_IRQ-1:0] irq_ff;
  reg  [`SBIE_NUM_IRQ-1:0] nxt_irq;

  // ========================================================
  // Request equations, each a level that drops with flag or enable
  always @* begin
    nxt_irq = {`SBIE_NUM_IRQ{1'b0}};
    nxt_irq[`SBIE_IRQ_TX_EMPTY] = en_tx_empty & tx_buf_empty_flag;
    nxt_irq[`SBIE_IRQ_TX_DONE]  = en_tx_end & tx_done_flag;
    nxt_irq[`SBIE_IRQ_RX_FULL]  = en_rx_full & rx_buf_full_flag;
    nxt_irq[`SBIE_IRQ_ERROR]    = sync_format & rx_lost_word_flag & (en_rx_full | en_nack);
    nxt_irq[`SBIE_IRQ_NACK]     = en_nack & (no_ack_flag | arbitration_lost_flag);
    nxt_irq[`SBIE_IRQ_STOP]     = en_stop & stop_seen_flag;
  end

  // ========================================================
  // Output registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= {`SBIE_NUM_IRQ{1'b0}};
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_vec = irq_ff;

endmodule

// file: dv/sbie_irq_enable_props.sv
// Port-level checks of the interrupt-enable block.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/1ps
module sbie_irq_enable_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        tx_buf_empty_flag,
  input logic        tx_done_flag,
  input logic        rx_buf_full_flag,
  input logic        no_ack_flag,
  input logic        arbitration_lost_flag,
  input logic        rx_lost_word_flag,
  input logic        stop_seen_flag,
  input logic        sync_format,
  input logic        rx_ack_bit,
  input logic        ack_sampled,
  input logic        xfer_start,
  input logic        tx_empty_irq,
  input logic        tx_done_irq,
  input logic        rx_full_irq,
  input logic        error_irq,
  input logic        nack_irq,
  input logic        stop_seen_irq,
  input logic        ack_check_en,
  input logic        halt_xfer
);
  logic [7:0] en_ff;
  // ========================================================
  // Mirror of the enable register, written on the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 8'h00;
    end else if (psel && penable && pwrite && paddr == 8'h00) begin
      en_ff <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_nack_judged;
    ack_sampled && rx_ack_bit && ack_check_en;
  endsequence
  // ========================================================
  // Request gating and halt
  a_tx_empty_gate: assert property (tx_empty_irq == $past(en_ff[7] & tx_buf_empty_flag))
    else $error("tx empty request wrong");
  a_tx_done_gate: assert property (tx_done_irq == $past(en_ff[6] & tx_done_flag))
    else $error("tx done request wrong");
  a_rx_full_gate: assert property (rx_full_irq == $past(en_ff[5] & rx_buf_full_flag))
    else $error("rx full request wrong");
  a_error_gate: assert property (error_irq == $past(sync_format & rx_lost_word_flag
    & (en_ff[5] | en_ff[4])))
    else $error("error request wrong");
  a_nack_gate: assert property (nack_irq == $past(en_ff[4]
    & (no_ack_flag | arbitration_lost_flag)))
    else $error("nack request wrong");
  a_stop_gate: assert property (stop_seen_irq == $past(en_ff[3] & stop_seen_flag))
    else $error("stop request wrong");
  a_halt_on_nack: assert property (s_nack_judged |=> halt_xfer)
    else $error("halt missing");
  a_halt_ignored: assert property (!halt_xfer && !ack_check_en |=> !halt_xfer)
    else $error("halt without check");
  a_halt_cleared: assert property (xfer_start && !ack_sampled |=> !halt_xfer [*2])
    else $error("halt not cleared");
  a_ack_chk_write: assert property (psel && penable && pwrite && paddr == 8'h00
    |=> ack_check_en == $past(pwdata[2]))
    else $error("ack check bit not written on access edge");
endmodule
bind sbie_irq_enable sbie_irq_enable_props u_props (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .tx_buf_empty_flag     (tx_buf_empty_flag),
  .tx_done_flag          (tx_done_flag),
  .rx_buf_full_flag      (rx_buf_full_flag),
  .no_ack_flag           (no_ack_flag),
  .arbitration_lost_flag (arbitration_lost_flag),
  .rx_lost_word_flag     (rx_lost_word_flag),
  .stop_seen_flag        (stop_seen_flag),
  .sync_format           (sync_format),
  .rx_ack_bit            (rx_ack_bit),
  .ack_sampled           (ack_sampled),
  .xfer_start            (xfer_start),
  .tx_empty_irq          (tx_empty_irq),
  .tx_done_irq           (tx_done_irq),
  .rx_full_irq           (rx_full_irq),
  .error_irq             (error_irq),
  .nack_irq              (nack_irq),
  .stop_seen_irq         (stop_seen_irq),
  .ack_check_en          (ack_check_en),
  .halt_xfer             (halt_xfer)
);

// file: dv/sbie_flag_model.sv
// Status flag logic beside the block; flags set and cleared by pulses.
// Assumes the bench drives pulses on pclk.
`timescale 1ns/1ps
module sbie_flag_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [6:0] set_v,
  input  logic [6:0] clr_v,
  output logic [6:0] flags_ff
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 7'h00;
    end else begin
      flags_ff <= (flags_ff | set_v) & ~clr_v;
    end
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench: APB register access, flag gating, ack judgement.
// Assumes zero-wait APB slave and flags from the flag model.
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        sync, ack_smp, rx_ack, xstart, halt, txa, ackc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  sset, sclr, fl;
  logic [5:0]  irqv;
  int          errors, comparisons, i, k;
  sbie_flag_model u_sbie_flag_model (.pclk(pclk), .presetn(presetn), .set_v(sset),
    .clr_v(sclr), .flags_ff(fl));
  sbie_irq_enable u_sbie_irq_enable (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_buf_empty_flag(fl[0]), .tx_done_flag(fl[1]),
    .rx_buf_full_flag(fl[2]), .no_ack_flag(fl[3]), .arbitration_lost_flag(fl[4]),
    .rx_lost_word_flag(fl[5]), .stop_seen_flag(fl[6]), .sync_format(sync),
    .rx_ack_bit(rx_ack), .ack_sampled(ack_smp), .xfer_start(xstart),
    .tx_empty_irq(irqv[0]), .tx_done_irq(irqv[1]), .rx_full_irq(irqv[2]),
    .error_irq(irqv[3]), .nack_irq(irqv[4]), .stop_seen_irq(irqv[5]), .tx_ack_bit(txa),
    .ack_check_en(ackc), .halt_xfer(halt));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] exp_irq(input logic [7:0] en, input logic [6:0] f,
                                          input logic s);
    exp_irq = {26'h0, en[3] & f[6], en[4] & (f[3] | f[4]), s & f[5] & (en[5] | en[4]),
               en[5] & f[2], en[6] & f[1], en[7] & f[0]};
  endfunction
  task wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
  endtask
  task flg(input logic [6:0] s, input logic [6:0] c);
    @(posedge pclk);
    sset <= s; sclr <= c;
    @(posedge pclk);
    sset <= 7'h00; sclr <= 7'h00;
    wait_n(1);
  endtask
  task pulse(input logic a, input logic v, input logic x);
    @(posedge pclk);
    ack_smp <= a; rx_ack <= v; xstart <= x;
    @(posedge pclk);
    ack_smp <= 1'b0; xstart <= 1'b0;
    #1;
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sset = 0; sclr = 0;
    sync = 1; ack_smp = 0; rx_ack = 0; xstart = 0; presetn = 0; errors = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    flg(7'h7f, 7'h00);
    chk({26'h0, irqv}, 32'h0);
    chk({30'h0, ackc, txa}, 32'h0);
    apb(1'b0, 8'h00, 32'h0); chk(r, 32'h0);
    for (k = 1; k >= 0; k--) begin
      @(posedge pclk);
      sync <= k[0];
      for (i = 3; i < 8; i++) begin
        apb(1'b1, 8'h00, 32'h1 << i);
        wait_n(1);
        chk({26'h0, irqv}, exp_irq(8'h1 << i, 7'h7f, k[0]));
      end
    end
    @(posedge pclk);
    sync <= 1'b1;
    apb(1'b1, 8'h00, 32'hf8);
    for (k = 0; k < 7; k++) begin
      flg(7'h00, 7'h1 << k);
      chk({26'h0, irqv}, exp_irq(8'hf8, 7'h7f & ~(7'h1 << k), 1'b1));
      flg(7'h1 << k, 7'h00);
    end
    apb(1'b1, 8'h00, 32'hff); apb(1'b0, 8'h00, 32'h0); chk(r, 32'hfd);
    chk({30'h0, ackc, txa}, 32'h3);
    apb(1'b1, 8'h04, 32'h0); chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h08, 32'h0); chk({31'h0, e}, 32'h1); chk(r, 32'h0);
    apb(1'b1, 8'h00, 32'h04);
    pulse(1'b1, 1'b0, 1'b0); chk({31'h0, halt}, 32'h0);
    pulse(1'b1, 1'b1, 1'b0); chk({31'h0, halt}, 32'h1);
    apb(1'b0, 8'h00, 32'h0); chk(r, 32'h06);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h40ff);
    chk({31'h0, e}, 32'h0);
    pulse(1'b0, 1'b0, 1'b1); chk({31'h0, halt}, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    pulse(1'b1, 1'b1, 1'b0); chk({31'h0, halt}, 32'h0);
    wrap_up;
  end
endmodule
